// file: hdl/vscr_pkg.sv
package vscr_pkg;

  // register offsets on the serial control port
  localparam logic [7:0] ADDR_HS_MODES  = 8'h00;
  localparam logic [7:0] ADDR_AUX_MODES = 8'h01;
  localparam logic [7:0] ADDR_RX_SET    = 8'h10;
  localparam logic [7:0] ADDR_PT_LOW    = 8'h11;
  localparam logic [7:0] ADDR_PT_HIGH   = 8'h12;
  localparam logic [7:0] ADDR_EQ_LOW    = 8'h13;
  localparam logic [7:0] ADDR_EQ_HIGH   = 8'h14;
  localparam logic [7:0] ADDR_TX_SET    = 8'h20;

  // reset values
  localparam logic [7:0] RST_HS_MODES  = 8'h40;
  localparam logic [7:0] RST_AUX_MODES = 8'h40;
  localparam logic [7:0] RST_RX_SET    = 8'h01;
  localparam logic [7:0] RST_PT        = 8'h00;
  localparam logic [7:0] RST_EQ        = 8'h00;
  localparam logic [7:0] RST_TX_SET    = 8'h03;

  // writable bits; the rest read as zero
  localparam logic [7:0] MODES_MASK  = 8'h43;
  localparam logic [7:0] RX_SET_MASK = 8'h01;
  localparam logic [7:0] TX_SET_MASK = 8'h0f;

  // field positions inside the registers
  localparam int ENABLE_BIT = 6;
  localparam int SEL_LSB    = 0;
  localparam int TERM_BIT   = 0;
  localparam int OUTPUT_CURRENT_HIGH_BIT = 0;
  localparam int TX_OTO_BIT = 1;
  localparam int OUTPUT_PREEMPH_LEVEL_LSB  = 2;

  // field positions inside the synchronised strap vector
  localparam int STRAP_W       = 8;
  localparam int STRAP_OCL     = 0;
  localparam int STRAP_OTO     = 1;
  localparam int STRAP_PE_LSB  = 2;
  localparam int STRAP_EQ      = 4;
  localparam int STRAP_SRC_LSB = 5;
  localparam int STRAP_EN      = 7;

  // channel count and termination pulse timing
  localparam int NUM_CH        = 16;
  localparam int PULSE_TIME_MS = 100;
  localparam int CLK_FREQ_KHZ  = 250000;
  localparam int PULSE_CYCLES  = PULSE_TIME_MS * CLK_FREQ_KHZ;
  localparam int PULSE_CNT_W   = 32;

  typedef struct packed {
    logic [STRAP_W-1:0]     sync1;
    logic [STRAP_W-1:0]     sync2;
    logic                   owned;
    logic [7:0]             hs_modes;
    logic [7:0]             aux_modes;
    logic [7:0]             rx_set;
    logic [7:0]             pt_low;
    logic [7:0]             pt_high;
    logic [7:0]             eq_low;
    logic [7:0]             eq_high;
    logic [7:0]             tx_set;
    logic [1:0]             prev_src;
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    logic [NUM_CH-1:0]      term_on;
    logic [7:0]             rdata;
    logic                   rvalid;
  } vscr_state_s;

  localparam vscr_state_s STATE_RESET = '{
    sync1:     8'h00,
    sync2:     8'h00,
    owned:     1'b0,
    hs_modes:  RST_HS_MODES,
    aux_modes: RST_AUX_MODES,
    rx_set:    RST_RX_SET,
    pt_low:    RST_PT,
    pt_high:   RST_PT,
    eq_low:    RST_EQ,
    eq_high:   RST_EQ,
    tx_set:    RST_TX_SET,
    prev_src:  2'h0,
    pulse_cnt: 32'h0000_0000,
    term_on:   16'hffff,
    rdata:     8'h00,
    rvalid:    1'b0
  };

endpackage

// file: hdl/vscr_config_regs.sv
`timescale 1ns/10ps
// How it works
// RULE_01 - aux source select codes 00..11 route aux source A..D to common port.
// RULE_02 - input term enable 0 turns input terminations off; 1 on, pulse-gated.
// RULE_03 - masked channels lose termination for 100 ms on a source switch.
// RULE_04 - pulse mask bits: B0-3, A0-3, then C3..C0, D3..D0.
// RULE_05 - each equalization bit: 0 gives 6 dB, 1 gives 12 dB.
// RULE_06 - equalization bits use the same channel order as the pulse mask.
// RULE_07 - two-bit pre-emphasis for all outputs: 0, 2, 4 or 6 dB.
// RULE_08 - output termination bit turns all output terminations off or on.
// RULE_09 - output current bit selects 10 mA or 20 mA for all outputs.
// RULE_10 - in parallel mode registers follow the strap pins directly.
// RULE_11 - straps rule only until first serial access; then serial owns registers.
// RULE_12 - parallel mode: aux enable reads 1, aux select follows hs straps.
// RULE_13 - parallel mode forces both pulse mask bytes to zero.
// RULE_14 - parallel mode copies the equalization strap into all sixteen bits.
// RULE_15 - parallel mode fixes input termination enable on.
// RULE_16 - hs enable 0 puts high speed channels in standby; 1 turns them on.
// RULE_17 - hs source select codes 00..11 route source A..D to the output.
// RULE_18 - pulse counter starts on each hs source change, restarts on another.
module vscr_config_regs #(
  parameter int unsigned PULSE_CYCLES = vscr_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // serial control register port (deframed, same clock)
  input  wire logic        reg_wr_en_in,
  input  wire logic        reg_rd_en_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_rvalid_out,
  // strap pins, asynchronous
  input  wire logic        strap_hs_enable_in,
  input  wire logic [1:0]  strap_source_select_in,
  input  wire logic        strap_eq_high_in,
  input  wire logic [1:0]  strap_preemph_pins_in,
  input  wire logic        strap_output_term_in,
  input  wire logic        strap_output_current_in,
  // controls to the analog paths
  output logic             parallel_mode_out,
  output logic             hs_channel_enable_out,
  output logic      [1:0]  hs_source_select_out,
  output logic             aux_enable_out,
  output logic      [1:0]  aux_source_select_out,
  output logic             input_term_enable_out,
  output logic      [15:0] input_term_pulse_mask_out,
  output logic      [15:0] input_term_on_out,
  output logic      [15:0] input_eq_high_out,
  output logic      [1:0]  output_preemph_level_out,
  output logic             output_term_enable_out,
  output logic             output_current_high_out
);

  vscr_pkg::vscr_state_s s_reg;
  vscr_pkg::vscr_state_s s_next;
  logic [vscr_pkg::STRAP_W-1:0] strap_vec;
  logic [vscr_pkg::PULSE_CNT_W-1:0] pulse_load;
  logic                  reg_access;
  logic [vscr_pkg::NUM_CH-1:0] pulse_mask_next;
  logic                  pulse_active_next;

  // strap pins gathered in the order of the strap field positions
  assign strap_vec = {strap_hs_enable_in, strap_source_select_in,
                      strap_eq_high_in, strap_preemph_pins_in,
                      strap_output_term_in, strap_output_current_in};
  assign pulse_load = vscr_pkg::PULSE_CNT_W'(PULSE_CYCLES);
  assign reg_access = reg_wr_en_in | reg_rd_en_in;

  // next-state logic for the whole block
  always_comb
  begin
    s_next        = s_reg;
    // two-stage synchroniser; only sync2 is read below
    s_next.sync1  = strap_vec;
    s_next.sync2  = s_reg.sync1;
    s_next.rvalid = 1'b0;

    // parallel mode: registers mirror the straps every cycle
    if (!s_reg.owned)
    begin
      s_next.hs_modes = 8'h00;
      s_next.hs_modes[vscr_pkg::ENABLE_BIT] =
        s_reg.sync2[vscr_pkg::STRAP_EN];                          // RULE_10
      s_next.hs_modes[vscr_pkg::SEL_LSB +: 2] =
        s_reg.sync2[vscr_pkg::STRAP_SRC_LSB +: 2];                // RULE_10
      s_next.aux_modes = 8'h00;
      s_next.aux_modes[vscr_pkg::ENABLE_BIT] = 1'b1;              // RULE_12
      s_next.aux_modes[vscr_pkg::SEL_LSB +: 2] =
        s_reg.sync2[vscr_pkg::STRAP_SRC_LSB +: 2];                // RULE_12
      s_next.rx_set = 8'h00;
      s_next.rx_set[vscr_pkg::TERM_BIT] = 1'b1;                   // RULE_15
      s_next.pt_low  = 8'h00;                                     // RULE_13
      s_next.pt_high = 8'h00;                                     // RULE_13
      s_next.eq_low  = {8{s_reg.sync2[vscr_pkg::STRAP_EQ]}};      // RULE_14
      s_next.eq_high = {8{s_reg.sync2[vscr_pkg::STRAP_EQ]}};      // RULE_14
      s_next.tx_set = 8'h00;
      s_next.tx_set[vscr_pkg::OUTPUT_PREEMPH_LEVEL_LSB +: 2] =
        s_reg.sync2[vscr_pkg::STRAP_PE_LSB +: 2];                 // RULE_10
      s_next.tx_set[vscr_pkg::TX_OTO_BIT] =
        s_reg.sync2[vscr_pkg::STRAP_OTO];                         // RULE_10
      s_next.tx_set[vscr_pkg::OUTPUT_CURRENT_HIGH_BIT] =
        s_reg.sync2[vscr_pkg::STRAP_OCL];                         // RULE_10
    end

    // any serial access hands the registers to the host for good
    if (reg_access)
    begin
      s_next.owned = 1'b1;                                        // RULE_11
    end

    // reads return the value held before this cycle's write
    if (reg_rd_en_in)
    begin
      s_next.rvalid = 1'b1;
      case (reg_addr_in)
        vscr_pkg::ADDR_HS_MODES:  s_next.rdata = s_reg.hs_modes;
        vscr_pkg::ADDR_AUX_MODES: s_next.rdata = s_reg.aux_modes;
        vscr_pkg::ADDR_RX_SET:    s_next.rdata = s_reg.rx_set;
        vscr_pkg::ADDR_PT_LOW:    s_next.rdata = s_reg.pt_low;
        vscr_pkg::ADDR_PT_HIGH:   s_next.rdata = s_reg.pt_high;
        vscr_pkg::ADDR_EQ_LOW:    s_next.rdata = s_reg.eq_low;
        vscr_pkg::ADDR_EQ_HIGH:   s_next.rdata = s_reg.eq_high;
        vscr_pkg::ADDR_TX_SET:    s_next.rdata = s_reg.tx_set;
        default:                  s_next.rdata = 8'h00;
      endcase
    end

    // writes land on top of the strap snapshot taken this cycle
    if (reg_wr_en_in)
    begin
      case (reg_addr_in)
        vscr_pkg::ADDR_HS_MODES:
          s_next.hs_modes = reg_wdata_in & vscr_pkg::MODES_MASK;  // RULE_17
        vscr_pkg::ADDR_AUX_MODES:
          s_next.aux_modes = reg_wdata_in & vscr_pkg::MODES_MASK; // RULE_01
        vscr_pkg::ADDR_RX_SET:
          s_next.rx_set = reg_wdata_in & vscr_pkg::RX_SET_MASK;   // RULE_02
        vscr_pkg::ADDR_PT_LOW:    s_next.pt_low  = reg_wdata_in;  // RULE_04
        vscr_pkg::ADDR_PT_HIGH:   s_next.pt_high = reg_wdata_in;  // RULE_04
        vscr_pkg::ADDR_EQ_LOW:    s_next.eq_low  = reg_wdata_in;  // RULE_06
        vscr_pkg::ADDR_EQ_HIGH:   s_next.eq_high = reg_wdata_in;  // RULE_06
        vscr_pkg::ADDR_TX_SET:
          s_next.tx_set = reg_wdata_in & vscr_pkg::TX_SET_MASK;   // RULE_07
        default:
          s_next.owned = 1'b1; // unmapped writes are dropped
      endcase
    end

    // termination pulse timer, restarted by every source change
    s_next.prev_src = s_next.hs_modes[vscr_pkg::SEL_LSB +: 2];
    if (s_next.prev_src != s_reg.prev_src)
    begin
      s_next.pulse_cnt = pulse_load;                              // RULE_18
    end
    else if (s_reg.pulse_cnt != '0)
    begin
      s_next.pulse_cnt = s_reg.pulse_cnt - 1'b1;                  // RULE_03
    end

    // per-channel termination: enable gated by mask while pulsing
    pulse_mask_next   = {s_next.pt_high, s_next.pt_low};
    pulse_active_next = (s_next.pulse_cnt != '0);
    if (s_next.rx_set[vscr_pkg::TERM_BIT])
    begin
      s_next.term_on = ~(pulse_mask_next &
                         {vscr_pkg::NUM_CH{pulse_active_next}});  // RULE_03
    end
    else
    begin
      s_next.term_on = '0;                                        // RULE_02
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= vscr_pkg::STATE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flip-flops
  assign reg_rdata_out             = s_reg.rdata;
  assign reg_rvalid_out            = s_reg.rvalid;
  assign parallel_mode_out         = ~s_reg.owned;
  assign hs_channel_enable_out     =
    s_reg.hs_modes[vscr_pkg::ENABLE_BIT];                         // RULE_16
  assign hs_source_select_out      =
    s_reg.hs_modes[vscr_pkg::SEL_LSB +: 2];                       // RULE_17
  assign aux_enable_out            = s_reg.aux_modes[vscr_pkg::ENABLE_BIT];
  assign aux_source_select_out     =
    s_reg.aux_modes[vscr_pkg::SEL_LSB +: 2];                      // RULE_01
  assign input_term_enable_out     = s_reg.rx_set[vscr_pkg::TERM_BIT];
  assign input_term_pulse_mask_out = {s_reg.pt_high, s_reg.pt_low};
  assign input_term_on_out         = s_reg.term_on;
  assign input_eq_high_out         =
    {s_reg.eq_high, s_reg.eq_low};                                // RULE_05
  assign output_preemph_level_out  =
    s_reg.tx_set[vscr_pkg::OUTPUT_PREEMPH_LEVEL_LSB +: 2];                       // RULE_07
  assign output_term_enable_out    =
    s_reg.tx_set[vscr_pkg::TX_OTO_BIT];                           // RULE_08
  assign output_current_high_out   =
    s_reg.tx_set[vscr_pkg::OUTPUT_CURRENT_HIGH_BIT];                           // RULE_09

  // checks on the register behaviour
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  aux_follow_a: assert property (parallel_mode_out |->   // RULE_12
      aux_source_select_out == hs_source_select_out && aux_enable_out)
    else $error("aux select or enable wrong in parallel mode");

  pulse_zero_a: assert property (parallel_mode_out |->   // RULE_13
      input_term_pulse_mask_out == 16'h0000)
    else $error("pulse mask not zero in parallel mode");

  eq_copy_a: assert property (parallel_mode_out |->   // RULE_14
      (input_eq_high_out == 16'h0000 || input_eq_high_out == 16'hffff))
    else $error("equalizer bits not replicated");

  rx_fixed_a: assert property (parallel_mode_out |->   // RULE_15
      input_term_enable_out)
    else $error("input termination not on in parallel mode");

  owned_sticky_a: assert property (   // RULE_11
      (reg_rd_en_in || reg_wr_en_in) |=> !parallel_mode_out [*3])
    else $error("serial access did not end parallel mode");

  hs_write_a: assert property (   // RULE_17
      reg_wr_en_in && reg_addr_in == vscr_pkg::ADDR_HS_MODES |=>
      hs_source_select_out == $past(reg_wdata_in[1:0]) &&
      hs_channel_enable_out == $past(reg_wdata_in[6]))
    else $error("hs modes write not applied");

  term_off_a: assert property (!input_term_enable_out |->   // RULE_02
      input_term_on_out == 16'h0000)
    else $error("input terminations on while disabled");

  // unmasked channels keep the plain enable level, even when it is off
  pulse_start_a: assert property (   // RULE_03
      $changed(hs_source_select_out) |->
      (input_term_on_out & input_term_pulse_mask_out) == 16'h0000 &&
      (input_term_on_out | input_term_pulse_mask_out) ==
      ({16{input_term_enable_out}} | input_term_pulse_mask_out))
    else $error("termination pulse not applied on source change");

  pulse_restart_a: assert property (   // RULE_18
      $changed(hs_source_select_out) |->
      s_reg.pulse_cnt == vscr_pkg::PULSE_CNT_W'(PULSE_CYCLES))
    else $error("pulse counter not reloaded on source change");

  // first edge after release still shows serial defaults, not straps
  strap_track_a: assert property (   // RULE_10
      parallel_mode_out && $past(parallel_mode_out) && $past(resetn_in) |->
      hs_source_select_out ==
        $past(s_reg.sync2[vscr_pkg::STRAP_SRC_LSB +: 2]) &&
      output_current_high_out == $past(s_reg.sync2[vscr_pkg::STRAP_OCL]))
    else $error("registers do not follow straps");

  first_access_c: cover property (parallel_mode_out ##1 !parallel_mode_out);
  pulse_seen_c: cover property (
      input_term_enable_out && input_term_on_out != 16'hffff);
  read_back_c: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);
  pulse_again_c: cover property (
      $changed(hs_source_select_out) ##[1:20] $changed(hs_source_select_out));

endmodule

// file: tb/vscr_host_model.sv
`timescale 1ns/10ps
// host controller: drives the strobe port and ties the strap pins
module vscr_host_model (
  // clock
  input  wire logic       clk_sys_in,
  // register port
  output logic            reg_wr_en_out,
  output logic            reg_rd_en_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in,
  // strap pins, packed like the synchronised strap vector
  output logic [7:0]      strap_out
);
  // quiet bus and all straps low at time zero
  initial
  begin
    reg_wr_en_out = 1'b0;
    reg_rd_en_out = 1'b0;
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    strap_out     = 8'h00;
  end

  // one write, launched and released at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_en_out = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_en_out = 1'b0;
    // released lines must not keep showing the last value
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask

  // one read; answer taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clk_sys_in);
    reg_addr_out  = a;
    reg_rd_en_out = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_en_out = 1'b0;
    reg_addr_out  = ~a;
    d = reg_rdata_in;
    v = reg_rvalid_in;
  endtask

  // straps only matter before the first access; host stops relying on them
  task automatic set_straps(input logic [7:0] s);
    @(negedge clk_sys_in);
    strap_out = s;
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        wr_en, rd_en, rvalid, par, hs_channel_enable, aux_en, term_en, oto, ocl;
  logic [7:0]  addr, wdata, rdata, strap;
  logic [1:0]  hs_sel, aux_sel, pe;
  logic [15:0] mask, term_on, eq;
  int          failures  = 0;
  int          cmp_count = 0;

  // 250 MHz system clock
  always #2 clk_sys_in = ~clk_sys_in;

  // short pulse count keeps the run brief
  vscr_config_regs #(.PULSE_CYCLES(10)) u_vscr_config_regs (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .strap_hs_enable_in(strap[7]), .strap_source_select_in(strap[6:5]),
    .strap_eq_high_in(strap[4]), .strap_preemph_pins_in(strap[3:2]),
    .strap_output_term_in(strap[1]), .strap_output_current_in(strap[0]),
    .parallel_mode_out(par), .hs_channel_enable_out(hs_channel_enable),
    .hs_source_select_out(hs_sel), .aux_enable_out(aux_en),
    .aux_source_select_out(aux_sel), .input_term_enable_out(term_en),
    .input_term_pulse_mask_out(mask), .input_term_on_out(term_on),
    .input_eq_high_out(eq), .output_preemph_level_out(pe),
    .output_term_enable_out(oto), .output_current_high_out(ocl));

  vscr_host_model u_vscr_host_model (
    .clk_sys_in(clk_sys_in), .reg_wr_en_out(wr_en), .reg_rd_en_out(rd_en),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid), .strap_out(strap));

  // single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // straps reach outputs three edges after a pin change
  task automatic t_parallel();
    for (int i = 0; i < 4; i++)
    begin
      u_vscr_host_model.set_straps({i[0], i[1:0], ~i[0], i[1:0], i[1], i[0]});
      repeat (4) @(negedge clk_sys_in);
      check({par, hs_channel_enable, hs_sel, aux_en, aux_sel, term_en},
            {1'b1, i[0], i[1:0], 1'b1, i[1:0], 1'b1});
      check(mask, 16'h0000);
      check(eq, {16{~i[0]}});
      check({pe, oto, ocl}, {i[1:0], i[1], i[0]});
    end
    $display("test parallel done");
  endtask

  // any access, even unmapped, ends strap control for good
  task automatic t_takeover();
    logic [7:0] d;
    logic       v;
    u_vscr_host_model.rd(8'h05, d, v);
    check({v, d}, 16'h0100);
    check(par, 1'b0);
    u_vscr_host_model.set_straps(8'h00);
    repeat (4) @(negedge clk_sys_in);
    check({hs_channel_enable, hs_sel, eq[0]}, 4'he);
    $display("test takeover done");
  endtask

  // every select and pre-emphasis code, reserved bits dropped
  task automatic t_fields();
    logic [7:0] d;
    logic       v;
    for (int i = 0; i < 4; i++)
    begin
      u_vscr_host_model.wr(vscr_pkg::ADDR_HS_MODES, {2'h0, 4'hf, i[1:0]});
      check({hs_channel_enable, hs_sel}, {1'b0, i[1:0]});
      u_vscr_host_model.wr(vscr_pkg::ADDR_AUX_MODES, {2'h1, 4'h0, i[1:0]});
      check({aux_en, aux_sel}, {1'b1, i[1:0]});
      u_vscr_host_model.wr(vscr_pkg::ADDR_TX_SET, {4'hf, i[1:0], i[0], ~i[0]});
      check({pe, oto, ocl}, {i[1:0], i[0], ~i[0]});
      u_vscr_host_model.rd(vscr_pkg::ADDR_TX_SET, d, v);
      check({v, d}, {1'b1, 4'h0, i[1:0], i[0], ~i[0]});
    end
    u_vscr_host_model.wr(vscr_pkg::ADDR_HS_MODES, 8'hff);
    check({hs_channel_enable, hs_sel}, 3'h7);
    u_vscr_host_model.rd(vscr_pkg::ADDR_HS_MODES, d, v);
    check({v, d}, {1'b1, 8'h43});
    u_vscr_host_model.wr(vscr_pkg::ADDR_EQ_LOW, 8'ha5);
    u_vscr_host_model.wr(vscr_pkg::ADDR_EQ_HIGH, 8'h3c);
    check(eq, 16'h3ca5);
    u_vscr_host_model.wr(vscr_pkg::ADDR_RX_SET, 8'hfe);
    check(term_en, 1'b0);
    $display("test fields done");
  endtask

  // masked channels drop termination; a second switch restarts the count
  task automatic t_pulse();
    logic [7:0] d;
    logic       v;
    u_vscr_host_model.wr(vscr_pkg::ADDR_RX_SET, 8'h01);
    check(term_en, 1'b1);
    u_vscr_host_model.wr(vscr_pkg::ADDR_PT_LOW, 8'h0f);
    u_vscr_host_model.wr(vscr_pkg::ADDR_PT_HIGH, 8'h80);
    check(term_on, 16'hffff);
    u_vscr_host_model.wr(vscr_pkg::ADDR_HS_MODES, 8'h41);
    check(term_on, 16'h7ff0);
    repeat (4) @(negedge clk_sys_in);
    u_vscr_host_model.wr(vscr_pkg::ADDR_HS_MODES, 8'h42);
    repeat (6) @(negedge clk_sys_in);
    check(term_on, 16'h7ff0);
    repeat (6) @(negedge clk_sys_in);
    check(term_on, 16'hffff);
    u_vscr_host_model.rd(vscr_pkg::ADDR_PT_HIGH, d, v);
    check({v, d}, {1'b1, 8'h80});
    $display("test pulse done");
  endtask

  // mid-run reset brings back the defaults, then strap control again
  task automatic t_reset();
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    check({par, hs_channel_enable, hs_sel, aux_en, aux_sel, term_en}, 8'hc9);
    check(term_on, 16'hffff);
    check({rvalid, rdata, pe, oto, ocl}, 13'h0003);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    check({par, hs_channel_enable, hs_sel, aux_en, aux_sel, term_en}, 8'h89);
    check(eq, 16'h0000);
    check({pe, oto, ocl}, 4'h0);
    $display("test reset done");
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    resetn_in = 1'b1;
    t_parallel();
    t_takeover();
    t_fields();
    t_pulse();
    t_reset();
    tally_and_finish();
  end
endmodule
